/* File: phy_mgmt_pkg.sv */
// Constants, types and register map of the PHY management and negotiation block.
// Assumes a 10 MHz system clock and an APB slave with 32-bit data.
// Functional notes
// - Management clock is system clock divided by a programmable value; software keeps it at most 2.5 MHz.
// - Auto-negotiation is enabled after reset; control bit 12 reads one.
// - Writing control bit 12 to zero turns auto-negotiation off.
// - Advertisement word is sent to the partner as fast-link pulse bursts.
// - On completion diag status bits 11:10 show the chosen duplex and speed.
// - On failure diag bit 12 is set and negotiation restarts from the start.
// - Writing one to control bit 9 restarts auto-negotiation.
// - Config bit 4 is polarity reverse, config bit 5 disables auto polarity.
// - By default polarity is automatic; bit 4 reports the detector's inversion.
// - With auto polarity disabled, bit 4 selects the receive polarity.
// - Straight or crossover pair selection is automatic, steered by its control register.
// - Two indicator outputs show conditions chosen in the indicator config register.
// - Indicators stay undriven after reset until software selects the hardware function.
package phy_mgmt_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_ADV = 8'h04;
   localparam logic [7:0] OFS_CFG = 8'h08;
   localparam logic [7:0] OFS_DIAG = 8'h0C;
   localparam logic [7:0] OFS_IND = 8'h10;
   localparam logic [7:0] OFS_XOVER = 8'h14;
   localparam logic [7:0] OFS_MDIV = 8'h18;
   localparam logic [7:0] OFS_ISTAT = 8'h1C;
   localparam logic [7:0] OFS_IMASK = 8'h20;
   // Field positions
   localparam int CTRL_AN_EN_BIT = 12;
   localparam int CTRL_RESTART_BIT = 9;
   localparam int CTRL_SPEED_BIT = 13;
   localparam int CTRL_DUPLEX_BIT = 8;
   localparam int CFG_POLREV_BIT = 4;
   localparam int CFG_APD_BIT = 5;
   localparam int DIAG_FAIL_BIT = 12;
   localparam int DIAG_DUPLEX_RESULT_BIT = 11;
   localparam int DIAG_RATE_BIT = 10;
   localparam int DIAG_DONE_BIT = 0;
   localparam int XO_AUTO_BIT = 0;
   localparam int XO_FORCE_BIT = 1;
   localparam int INT_DONE_BIT = 0;
   localparam int INT_FAIL_BIT = 1;
   // Reset values
   localparam logic [15:0] CTRL_RST = 16'h3100;
   localparam logic [15:0] ADV_RST = 16'h01E1;
   localparam logic [15:0] IND_RST = 16'h0010;
   localparam logic [1:0] XOVER_RST = 2'h1;
   localparam logic [7:0] MDIV_RST = 8'h01;
   // Timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int MDC_MAX_KHZ = 2500;
   localparam int FLP_SLOT_NS = 62500;
   localparam int FLP_SLOT_CYC = FLP_SLOT_NS / CLK_PERIOD_NS;
   localparam int AN_WAIT_US = 2000;
   localparam int AN_WAIT_CYC = AN_WAIT_US * 1000 / CLK_PERIOD_NS;
   localparam int XOVER_SLOT_US = 100;
   localparam int XOVER_SLOT_CYC = XOVER_SLOT_US * 1000 / CLK_PERIOD_NS;
   localparam int LP_EDGES_MIN = 8;

   typedef enum logic [2:0] {
      AN_OFF = 3'b000,
      AN_SEND = 3'b001,
      AN_LISTEN = 3'b010,
      AN_LINK = 3'b011,
      AN_FAIL = 3'b100
   } an_state_t;

   typedef struct packed {
      logic fail;
      logic duplex;
      logic speed;
   } an_result_t;

   typedef struct packed {
      logic [6:0] rsvd;
      logic hw_en;
      logic [3:0] sel1;
      logic [3:0] sel0;
   } ind_cfg_t;
endpackage

/* File: bit_sync2.sv */
// Two-flop synchroniser for levels entering the system clock domain.
// Multi-bit use is only for quasi-static words.
`timescale 1ns/1ps
module bit_sync2 #(
   parameter int W = 1
) (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_q;

   // First stage feeds only the second
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         meta_q <= '0;
         q_o <= '0;
      end else begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule

/* File: flp_burst_tx.sv */
// Fast-link pulse burst sender: 17 clock slots interleaved with 16 data slots.
// Assumes a start pulse only while idle; start while busy is ignored.
`timescale 1ns/1ps
module flp_burst_tx #(
   parameter int SLOT_CYC = 625
) (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic start_i,
   input wire logic [15:0] word_i,
   output logic pulse_o,
   output logic busy_o
);
   localparam int TW = $clog2(SLOT_CYC);
   localparam logic [TW-1:0] SLOT_LAST = TW'(SLOT_CYC - 1);

   if (SLOT_CYC < 2) begin : g_chk
      $error("SLOT_CYC must be at least 2");
   end

   logic [TW-1:0] tmr_q;
   logic [5:0] slot_q;
   logic [15:0] word_q;

   // Even slots carry clock pulses, odd slots carry data bits LSB first
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         busy_o <= 1'b0;
         pulse_o <= 1'b0;
         tmr_q <= '0;
         slot_q <= 6'h00;
         word_q <= 16'h0000;
      end else begin
         pulse_o <= 1'b0;
         if (!busy_o) begin
            if (start_i) begin
               busy_o <= 1'b1;
               slot_q <= 6'h00;
               tmr_q <= '0;
               word_q <= word_i;
               pulse_o <= 1'b1;
            end
         end else if (tmr_q == SLOT_LAST) begin
            tmr_q <= '0;
            if (slot_q == 6'd32) begin
               busy_o <= 1'b0;
            end else begin
               slot_q <= slot_q + 6'h01;
               pulse_o <= slot_q[0] | word_q[slot_q[4:1]];
            end
         end else begin
            tmr_q <= tmr_q + TW'(1);
         end
      end
   end
endmodule

/* File: phy_autoneg_mgmt_control.sv */
// PHY management control: APB registers, auto-negotiation, polarity,
// crossover, management clock divider and indicator selection.
// Assumes link_clk_i, rx_pol_det_i and partner ability are asynchronous.
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module phy_autoneg_mgmt_control
   import phy_mgmt_pkg::*;
#(
   parameter int AN_WAIT = AN_WAIT_CYC
) (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic link_clk_i,
   input wire logic [15:0] lp_ability_i,
   input wire logic rx_pol_det_i,
   output logic flp_pulse_o,
   output logic mgmt_clk_o,
   output logic rx_invert_o,
   output logic mdix_o,
   output logic indicator_out_0_o,
   output logic indicator_out_1_o,
   output logic [1:0] indicator_oe_o,
   output logic irq_o
);
   localparam int WW = $clog2(AN_WAIT + 1);
   localparam int XW = $clog2(XOVER_SLOT_CYC);

   if (AN_WAIT < 2 * LP_EDGES_MIN) begin : g_chk
      $error("AN_WAIT too short");
   end

   logic an_en_q, spd_q, dup_q, restart_q, cfg_rev_q, apd_q, rx_inv_q;
   logic [15:0] adv_q;
   ind_cfg_t ind_q;
   logic [1:0] xo_q;
   logic [7:0] mdiv_q, mdc_cnt_q;
   logic [1:0] istat_q, imask_q;
   an_state_t st_q;
   an_result_t res_q;
   logic done_q, flp_start_q, flp_busy, lk_s, lk_d_q, det_s;
   logic [15:0] lp_s;
   logic [WW-1:0] wait_q;
   logic [7:0] edges_q;
   logic [XW-1:0] xo_tmr_q;
   logic [31:0] rd_d;
   logic acc, wr, ev_done, ev_fail, timeout, an_ok, com_dup, com_spd;
   logic [15:0] common;
   logic [1:0] ind_d;

   default clocking @(posedge mclk_i); endclocking
   default disable iff (reset_i);

   // Outside levels pass two flops before use
   bit_sync2 #(.W(18)) u_sync (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .d_i({link_clk_i, rx_pol_det_i, lp_ability_i}),
      .q_o({lk_s, det_s, lp_s})
   );

   flp_burst_tx #(.SLOT_CYC(FLP_SLOT_CYC)) u_flp (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .start_i(flp_start_q),
      .word_i(adv_q),
      .pulse_o(flp_pulse_o),
      .busy_o(flp_busy)
   );

   // APB: one wait state, answer from registers
   assign acc = psel_i & penable_i & pready_o;
   assign wr = acc & pwrite_i;

   always_comb begin
      rd_d = 32'h0000_0000;
      case (paddr_i)
         OFS_CTRL: begin
            rd_d[CTRL_AN_EN_BIT] = an_en_q;
            rd_d[CTRL_SPEED_BIT] = spd_q;
            rd_d[CTRL_DUPLEX_BIT] = dup_q;
         end
         OFS_ADV: rd_d[15:0] = adv_q;
         OFS_CFG: begin
            rd_d[CFG_POLREV_BIT] = apd_q ? cfg_rev_q : det_s;
            rd_d[CFG_APD_BIT] = apd_q;
         end
         OFS_DIAG: begin
            rd_d[DIAG_FAIL_BIT] = res_q.fail;
            rd_d[DIAG_DUPLEX_RESULT_BIT] = res_q.duplex;
            rd_d[DIAG_RATE_BIT] = res_q.speed;
            rd_d[DIAG_DONE_BIT] = done_q;
         end
         OFS_IND: rd_d[15:0] = {7'h00, ind_q.hw_en, ind_q.sel1, ind_q.sel0};
         OFS_XOVER: rd_d[1:0] = xo_q;
         OFS_MDIV: rd_d[7:0] = mdiv_q;
         OFS_ISTAT: rd_d[1:0] = istat_q;
         OFS_IMASK: rd_d[1:0] = imask_q;
         default: rd_d = 32'h0000_0000;
      endcase
   end

   // Answer phase; unmapped addresses raise pslverr
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
      end else begin
         pready_o <= psel_i & penable_i & ~pready_o;
         if (psel_i & penable_i & ~pready_o) begin
            prdata_o <= pwrite_i ? 32'h0000_0000 : rd_d;
            pslverr_o <= (paddr_i > OFS_IMASK) | (paddr_i[1:0] != 2'h0);
         end else begin
            pslverr_o <= 1'b0;
         end
      end
   end

   // Control register; restart is a pulse, never stored
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         an_en_q <= CTRL_RST[CTRL_AN_EN_BIT];
         spd_q <= CTRL_RST[CTRL_SPEED_BIT];
         dup_q <= CTRL_RST[CTRL_DUPLEX_BIT];
         restart_q <= 1'b0;
      end else begin
         restart_q <= 1'b0;
         if (wr && paddr_i == OFS_CTRL) begin
            an_en_q <= pwdata_i[CTRL_AN_EN_BIT];
            spd_q <= pwdata_i[CTRL_SPEED_BIT];
            dup_q <= pwdata_i[CTRL_DUPLEX_BIT];
            restart_q <= pwdata_i[CTRL_RESTART_BIT];
         end
      end
   end

   // Configuration registers
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         adv_q <= ADV_RST;
         cfg_rev_q <= 1'b0;
         apd_q <= 1'b0;
         ind_q <= IND_RST;
         xo_q <= XOVER_RST;
         mdiv_q <= MDIV_RST;
         imask_q <= 2'h0;
      end else if (wr) begin
         case (paddr_i)
            OFS_ADV: adv_q <= pwdata_i[15:0];
            OFS_CFG: begin
               cfg_rev_q <= pwdata_i[CFG_POLREV_BIT];
               apd_q <= pwdata_i[CFG_APD_BIT];
            end
            OFS_IND: ind_q <= {7'h00, pwdata_i[8:0]};
            OFS_XOVER: xo_q <= pwdata_i[1:0];
            OFS_MDIV: mdiv_q <= pwdata_i[7:0];
            OFS_IMASK: imask_q <= pwdata_i[1:0];
            default: ;
         endcase
      end
   end

   // Management clock: f = fclk / (2 * (div + 1)); software keeps it <= 2.5 MHz
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         mdc_cnt_q <= 8'h00;
         mgmt_clk_o <= 1'b0;
      end else if (mdc_cnt_q >= mdiv_q) begin
         mdc_cnt_q <= 8'h00;
         mgmt_clk_o <= ~mgmt_clk_o;
      end else begin
         mdc_cnt_q <= mdc_cnt_q + 8'h01;
      end
   end

   // Resolution against the partner's ability word
   assign common = adv_q & lp_s;
   assign com_spd = common[8] | common[7];
   assign com_dup = common[8] | (~com_spd & common[6]);
   assign timeout = (wait_q == WW'(AN_WAIT));
   assign an_ok = (edges_q >= 8'(LP_EDGES_MIN)) & (|common[8:5]);
   assign ev_done = (st_q == AN_LISTEN) & timeout & an_ok;
   assign ev_fail = (st_q == AN_LISTEN) & timeout & ~an_ok;

   // Negotiation sequence; restart or disable overrides any state
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         st_q <= AN_OFF;
         flp_start_q <= 1'b0;
         wait_q <= '0;
      end else begin
         flp_start_q <= 1'b0;
         if (!an_en_q) begin
            st_q <= AN_OFF;
         end else if (restart_q) begin
            st_q <= AN_SEND;
            flp_start_q <= ~flp_busy;
         end else begin
            case (st_q)
               AN_OFF: begin
                  st_q <= AN_SEND;
                  flp_start_q <= ~flp_busy;
               end
               AN_SEND: begin
                  // Advertisement goes out as one burst
                  if (!flp_busy && !flp_start_q) begin
                     st_q <= AN_LISTEN;
                     wait_q <= '0;
                  end
               end
               AN_LISTEN: begin
                  wait_q <= wait_q + WW'(1);
                  if (ev_done) begin
                     st_q <= AN_LINK;
                  end else if (ev_fail) begin
                     st_q <= AN_FAIL;
                  end
               end
               AN_FAIL: begin
                  st_q <= AN_SEND;
                  flp_start_q <= 1'b1;
               end
               AN_LINK: st_q <= AN_LINK;
               default: st_q <= AN_OFF;
            endcase
         end
      end
   end

   // Partner pulses counted from the sampled link clock
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         lk_d_q <= 1'b0;
         edges_q <= 8'h00;
      end else begin
         lk_d_q <= lk_s;
         if (st_q != AN_LISTEN) begin
            edges_q <= 8'h00;
         end else if (lk_s && !lk_d_q && edges_q != 8'hFF) begin
            edges_q <= edges_q + 8'h01;
         end
      end
   end

   // Result; fail flag holds until a later negotiation succeeds or negotiation is disabled
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         res_q <= '0;
         done_q <= 1'b0;
      end else if (!an_en_q) begin
         res_q <= '{fail: 1'b0, duplex: dup_q, speed: spd_q};
         done_q <= 1'b0;
      end else if (ev_done) begin
         res_q <= '{fail: 1'b0, duplex: com_dup, speed: com_spd};
         done_q <= 1'b1;
      end else if (ev_fail) begin
         res_q.fail <= 1'b1;
         done_q <= 1'b0;
      end else if (restart_q) begin
         done_q <= 1'b0;
      end
   end

   // Sticky events; a new event wins over a same-cycle clear
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         istat_q <= 2'h0;
         irq_o <= 1'b0;
      end else begin
         istat_q <= (istat_q & ~((wr && paddr_i == OFS_ISTAT) ? pwdata_i[1:0] : 2'h0))
                    | {ev_fail, ev_done};
         irq_o <= |(istat_q & imask_q);
      end
   end

   // Receive polarity: detector in auto mode, register in manual mode
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         rx_inv_q <= 1'b0;
      end else begin
         rx_inv_q <= apd_q ? cfg_rev_q : det_s;
      end
   end
   assign rx_invert_o = rx_inv_q;

   // Crossover hunt toggles pairs until link; forced choice when auto is off
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         mdix_o <= 1'b0;
         xo_tmr_q <= '0;
      end else if (!xo_q[XO_AUTO_BIT]) begin
         mdix_o <= xo_q[XO_FORCE_BIT];
         xo_tmr_q <= '0;
      end else if (st_q != AN_LINK) begin
         if (xo_tmr_q == XW'(XOVER_SLOT_CYC - 1)) begin
            xo_tmr_q <= '0;
            mdix_o <= ~mdix_o;
         end else begin
            xo_tmr_q <= xo_tmr_q + XW'(1);
         end
      end
   end

   // Indicator source selection
   function automatic logic ind_src(input logic [3:0] sel);
      case (sel)
         4'h0: ind_src = (st_q == AN_LINK);
         4'h1: ind_src = res_q.speed;
         4'h2: ind_src = res_q.duplex;
         4'h3: ind_src = (st_q == AN_SEND) | (st_q == AN_LISTEN);
         4'h4: ind_src = res_q.fail;
         4'h5: ind_src = flp_pulse_o;
         4'h6: ind_src = mdix_o;
         default: ind_src = 1'b0;
      endcase
   endfunction

   always_comb ind_d = {ind_src(ind_q.sel1), ind_src(ind_q.sel0)};

   // Pins stay released until the hardware function is chosen
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         indicator_out_0_o <= 1'b0;
         indicator_out_1_o <= 1'b0;
         indicator_oe_o <= 2'h0;
      end else begin
         indicator_out_0_o <= ind_q.hw_en & ind_d[0];
         indicator_out_1_o <= ind_q.hw_en & ind_d[1];
         indicator_oe_o <= {2{ind_q.hw_en}};
      end
   end

   a_restart_reads_zero: assert property (
      (pready_o && !pwrite_i && paddr_i == OFS_CTRL) |-> !prdata_o[CTRL_RESTART_BIT])
      else $error("restart bit read back as one");
   a_disable_stops_an: assert property (
      !an_en_q |=> st_q == AN_OFF)
      else $error("negotiation running while disabled");
   a_fail_restarts: assert property (
      st_q == AN_FAIL && an_en_q && !restart_q |=> st_q == AN_SEND && flp_start_q)
      else $error("failure did not restart negotiation");
   a_fail_flag_set: assert property (
      ev_fail && an_en_q |=> res_q.fail && !done_q)
      else $error("failure flag not set");
   a_result_bits: assert property (
      ev_done && an_en_q |=> res_q.duplex == $past(com_dup) && res_q.speed == $past(com_spd))
      else $error("result bits wrong");
   a_restart_cmd: assert property (
      restart_q && an_en_q |=> st_q == AN_SEND)
      else $error("restart ignored");
   a_manual_polarity: assert property (
      apd_q && $stable(apd_q) |=> rx_invert_o == $past(cfg_rev_q))
      else $error("manual polarity not applied");
   a_auto_polarity: assert property (
      !apd_q |=> rx_invert_o == $past(det_s))
      else $error("auto polarity not following detector");
   a_ind_released: assert property (
      !ind_q.hw_en |=> indicator_oe_o == 2'h0 && !indicator_out_0_o && !indicator_out_1_o)
      else $error("indicator driven in gpio mode");
   a_burst_sent: assert property (
      st_q == AN_OFF && an_en_q && !restart_q |=> ##1 flp_busy [*2])
      else $error("advertisement burst not sent");
endmodule

/* File: phy_link_partner.sv */
// Behavioural link partner: link pulses, ability word and polarity detector.
// Assumes the bench switches it on and off between its own clock edges.
`timescale 1ns/1ps
module phy_link_partner (
   input wire logic en_i,
   input wire logic pol_i,
   input wire logic [15:0] ability_i,
   output logic link_clk_o,
   output logic [15:0] ability_o,
   output logic pol_det_o
);
   // Link clock of 800 ns, still and low while the partner is silent
   initial begin
      link_clk_o = 1'b0;
      #37;
      forever begin
         #400;
         link_clk_o = en_i ? ~link_clk_o : 1'b0;
      end
   end
   // A silent partner offers no valid word, so show its inverse
   assign ability_o = en_i ? ability_i : ~ability_i;
   assign pol_det_o = pol_i;
endmodule

/* File: phy_autoneg_mgmt_control_tb.sv */
// Self-checking bench for the PHY management and negotiation block.
// Assumes the register map and timing of the package; APB master by task.
`timescale 1ns/1ps
module phy_autoneg_mgmt_control_tb;
   import phy_mgmt_pkg::*;
   logic mclk_i = 1'b0;
   logic reset_i = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, link_clk, pol_det, flp_pulse, mgmt_clk, rx_inv, mdix, ind0, ind1, irq;
   logic [15:0] lp_ab;
   logic [1:0] ind_oe;
   logic part_en = 1'b1;
   logic part_pol = 1'b0;
   logic [15:0] part_ab = 16'h0061;
   int err_count = 0;
   int checks = 0;
   int pulses = 0;

   always #50 mclk_i = ~mclk_i;

   phy_autoneg_mgmt_control #(.AN_WAIT(200)) i_phy_autoneg_mgmt_control (
      .mclk_i(mclk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .link_clk_i(link_clk),
      .lp_ability_i(lp_ab), .rx_pol_det_i(pol_det), .flp_pulse_o(flp_pulse),
      .mgmt_clk_o(mgmt_clk), .rx_invert_o(rx_inv), .mdix_o(mdix),
      .indicator_out_0_o(ind0), .indicator_out_1_o(ind1), .indicator_oe_o(ind_oe),
      .irq_o(irq));

   phy_link_partner i_phy_link_partner (.en_i(part_en), .pol_i(part_pol),
      .ability_i(part_ab), .link_clk_o(link_clk), .ability_o(lp_ab), .pol_det_o(pol_det));

   // Count fast link pulses seen on the line
   always @(posedge mclk_i) if (flp_pulse === 1'b1) pulses <= pulses + 1;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One APB transfer; waits for pready without a bound and checks that one wait cycle was counted
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge mclk_i);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk_i);
      penable <= 1'b1;
      @(posedge mclk_i);
      while (pready !== 1'b1) begin
         n++;
         @(posedge mclk_i);
      end
      chk(n, 32'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r & m, exp);
   endtask

   // Poll the diag word; the outcome needs a whole burst, so the bound is wide
   task automatic wait_diag(input logic [31:0] m, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      for (int i = 0; i < 300; i++) begin
         apb(1'b0, OFS_DIAG, 32'h0, r, e);
         if ((r & m) === exp) break;
         repeat (100) @(posedge mclk_i);
      end
      chk(r & m, exp);
   endtask

   // Cycles between two rising edges of the management clock
   task automatic mgmt_period(input int exp);
      int n;
      logic p;
      repeat (2) begin
         n = 0;
         do begin
            p = mgmt_clk;
            @(negedge mclk_i);
            n++;
         end while (!(p === 1'b0 && mgmt_clk === 1'b1) && n < 100);
      end
      chk(n, exp);
   endtask

   task automatic t_reset();
      logic [31:0] r;
      logic e;
      rchk(OFS_CTRL, 32'hFFFF_FFFF, {16'h0, CTRL_RST});
      rchk(OFS_IND, 32'hFFFF_FFFF, {16'h0, IND_RST});
      chk({ind_oe, ind0, ind1}, 32'h0);
      apb(1'b0, 8'h24, 32'h0, r, e);
      chk(r, 32'h0);
      chk(e, 1'b1);
      mgmt_period(4);
      wr(OFS_MDIV, 32'h3);
      mgmt_period(8);
      wr(OFS_MDIV, 32'h1);
   endtask

   task automatic t_polarity();
      part_pol <= 1'b1;
      repeat (6) @(posedge mclk_i);
      rchk(OFS_CFG, 32'h30, 32'h10);
      chk(rx_inv, 1'b1);
      wr(OFS_CFG, 32'h20);
      repeat (4) @(posedge mclk_i);
      chk(rx_inv, 1'b0);
      rchk(OFS_CFG, 32'h30, 32'h20);
      wr(OFS_CFG, 32'h30);
      repeat (4) @(posedge mclk_i);
      chk(rx_inv, 1'b1);
      wr(OFS_CFG, 32'h0);
   endtask

   task automatic t_xover_ind();
      wr(OFS_XOVER, 32'h2);
      wr(OFS_IND, 32'h166);
      repeat (4) @(posedge mclk_i);
      chk({mdix, ind_oe, ind1, ind0}, 5'h1F);
      wr(OFS_XOVER, 32'h0);
      repeat (4) @(posedge mclk_i);
      chk({mdix, ind_oe, ind1, ind0}, 5'h0C);
      wr(OFS_XOVER, 32'h1);
      wr(OFS_IND, 32'h140);
   endtask

   // Common ability 10M half and full: duplex set, speed clear
   task automatic t_success();
      wr(OFS_IMASK, 32'h3);
      wait_diag(32'h1C01, 32'h0801);
      chk(pulses, 22);
      repeat (2) @(posedge mclk_i);
      chk({irq, ind0}, 2'b11);
      wr(OFS_ISTAT, 32'h1);
      repeat (3) @(posedge mclk_i);
      chk(irq, 1'b0);
   endtask

   task automatic t_fail();
      int p0;
      part_en <= 1'b0;
      wr(OFS_IMASK, 32'h1);
      p0 = pulses;
      wr(OFS_CTRL, 32'h3300);
      rchk(OFS_CTRL, 32'hFFFF_FFFF, 32'h3100);
      wait_diag(32'h1000, 32'h1000);
      chk((pulses - p0) >= 22, 1);
      chk({irq, ind1}, 2'b01);
      p0 = pulses;
      repeat (1300) @(posedge mclk_i);
      chk(pulses > p0, 1);
      wr(OFS_IMASK, 32'h3);
      repeat (3) @(posedge mclk_i);
      chk(irq, 1'b1);
      wr(OFS_ISTAT, 32'h3);
      repeat (3) @(posedge mclk_i);
      chk(irq, 1'b0);
   endtask

   // A burst in flight may finish; afterwards the line must stay silent
   task automatic t_disable();
      int p0;
      wr(OFS_CTRL, 32'h2100);
      rchk(OFS_CTRL, 32'hFFFF_FFFF, 32'h2100);
      rchk(OFS_DIAG, 32'h1000, 32'h0);
      repeat (21000) @(posedge mclk_i);
      p0 = pulses;
      repeat (2000) @(posedge mclk_i);
      chk(pulses, p0);
   endtask

   task automatic results();
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      repeat (2) @(posedge mclk_i);
      reset_i <= 1'b0;
      t_reset();
      t_polarity();
      t_xover_ind();
      t_success();
      t_fail();
      t_disable();
      results();
   end

   // Whole run is about 70000 cycles
   initial begin
      #9000000;
      err_count++;
      results();
   end
endmodule
